/* verilog/dam_pkg.sv */
/*
 * Shared constants and types of the drive auxiliary monitor and timer:
 * tick timing, register offsets, field positions, reset values, state
 * and output encodings.
 * Assumes a 20 MHz system clock and a 32-bit classic Wishbone master.
 */
`default_nettype none

package dam_pkg;

    // timing: all supervision runs on a 100 ms tick
    localparam int CLK_PERIOD_NS = 50;
    localparam int TICK_TIME_MS = 100;
    localparam int TICK_CYCLES = TICK_TIME_MS * 1_000_000 / CLK_PERIOD_NS;
    localparam int TENTH_MIN_TIME_MS = 6000;
    localparam int TICKS_PER_TENTH_MIN = TENTH_MIN_TIME_MS / TICK_TIME_MS;

    // scaling constants
    localparam logic [15:0] AI_FULL_SCALE = 16'h03E8;
    localparam logic [31:0] POWER_UNITY = 32'h0000_03E8;
    localparam logic [31:0] WAKE_UNITY = 32'h0000_0064;
    localparam logic [7:0] FAN_TEMP_C = 8'h28;

    // register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_CUR_A = 8'h04;
    localparam logic [7:0] ADDR_CUR_B = 8'h08;
    localparam logic [7:0] ADDR_DURATION = 8'h0C;
    localparam logic [7:0] ADDR_AI1_LIMITS = 8'h10;
    localparam logic [7:0] ADDR_TEMP = 8'h14;
    localparam logic [7:0] ADDR_WAKE = 8'h18;
    localparam logic [7:0] ADDR_SLEEP = 8'h1C;
    localparam logic [7:0] ADDR_RUN_REACH = 8'h20;
    localparam logic [7:0] ADDR_POWER_COEF = 8'h24;
    localparam logic [7:0] ADDR_STATUS = 8'h28;
    localparam logic [7:0] ADDR_MONITOR = 8'h2C;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h30;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h34;

    // control field positions
    localparam int CTRL_TIMER_EN_BIT = 0;
    localparam int CTRL_SRC_LSB = 1;
    localparam int CTRL_FAN_BIT = 3;

    // writable bit masks
    localparam logic [31:0] MASK_CTRL = 32'h0000_000F;
    localparam logic [31:0] MASK_FULL = 32'hFFFF_FFFF;
    localparam logic [31:0] MASK_LOW16 = 32'h0000_FFFF;
    localparam logic [31:0] MASK_TEMP = 32'h0000_00FF;
    localparam logic [31:0] MASK_WAKE = 32'hFFFF_00FF;
    localparam logic [31:0] MASK_IRQ = 32'h0000_003F;

    // reset values
    localparam logic [31:0] RST_CTRL = 32'h0000_0000;
    localparam logic [31:0] RST_CUR = 32'h0000_03E8;
    localparam logic [31:0] RST_DURATION = 32'h0000_0000;
    localparam logic [31:0] RST_AI1_LIMITS = 32'h02A8_0136;
    localparam logic [31:0] RST_TEMP = 32'h0000_004B;
    localparam logic [31:0] RST_WAKE = 32'h0000_004B;
    localparam logic [31:0] RST_SLEEP = 32'h0000_0000;
    localparam logic [31:0] RST_RUN_REACH = 32'h0000_0000;
    localparam logic [31:0] RST_POWER_COEF = 32'h0000_03E8;

    // duration source codes
    localparam logic [1:0] SRC_STORED = 2'h0;
    localparam logic [1:0] SRC_AI1 = 2'h1;
    localparam logic [1:0] SRC_AI2 = 2'h2;

    // interrupt event bits
    localparam int EV_TIMING = 0;
    localparam int EV_RUN_TIME = 1;
    localparam int EV_TEMP = 2;
    localparam int EV_AI1 = 3;
    localparam int EV_SLEEP = 4;
    localparam int EV_WAKE = 5;
    localparam int EV_W = 6;

    typedef enum logic [1:0] {
        ST_STOP,
        ST_RUN,
        ST_SLEEP,
        ST_DONE
    } dam_state_t;

    typedef struct packed {
        logic fan_on;
        logic run_time_reached;
        logic timing_reached;
        logic temp_reached;
        logic ai1_limit;
        logic cur_reach_b;
        logic cur_reach_a;
    } dam_do_t;

endpackage : dam_pkg

`default_nettype wire

/* verilog/dam_top.sv */
/*
 * Drive auxiliary monitor and timer: current-reach windows, analog
 * limit, heatsink and fan control, run timer, sleep/wakeup and output
 * power correction, configured over a classic Wishbone slave.
 * Assumes all measured quantities are sampled synchronously to clk_sys_i
 * and that run_cmd_i is the operator's level run command.
 */
// Decided for this implementation: the register addresses and the Wishbone slave port.
`default_nettype none

// Overview of operation
// - reach output high while current is within level plus/minus width
// - two independent reach detectors, level and width 0 to 300 percent
// - enabled timer counts run time from each start; disabled never stops
// - timer reaching duration stops drive and raises timing output
// - run timer clears at each start; remaining time is readable
// - duration source: stored, analog one, analog two; 3 reserved
// - stored duration in 0.1 minute units, 0 to 6500.0, reset zero
// - analog one outside low/high limits raises limit output
// - heatsink temperature at or above threshold raises output, default 75
// - fan mode 0: on while running, else on above 40 degrees
// - fan mode 1: fan always on
// - running with set frequency low for sleep delay enters sleep
// - asleep with run command, frequency high for wake delay restarts
// - both wake threshold and sleep frequency zero disable sleep
// - present run time reaching setting raises run-time output
// - reported power scaled by correction coefficient, 100 percent unity
module dam_top
    import dam_pkg::*;
#(
    parameter int TICK_DIV = TICK_CYCLES
)(
    // clock, reset, enable
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic ce_i,
    // wishbone slave
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // sampled drive quantities
    input wire logic run_cmd_i,
    input wire logic [15:0] current_i,
    input wire logic [15:0] ai1_i,
    input wire logic [15:0] ai2_i,
    input wire logic [7:0] heatsink_temp_i,
    input wire logic [15:0] set_freq_i,
    input wire logic [15:0] max_freq_i,
    input wire logic [15:0] output_power_i,
    // drive and digital outputs
    output dam_do_t do_o,
    output logic drive_run_o,
    output logic sleeping_o,
    output logic [15:0] run_timer_remaining_monitor_o,
    output logic [15:0] output_power_monitor_o,
    output logic irq_o
);

    logic [31:0] reg_ctrl;
    logic [31:0] reg_cur_a;
    logic [31:0] reg_cur_b;
    logic [31:0] reg_duration;
    logic [31:0] reg_ai1;
    logic [31:0] reg_temp;
    logic [31:0] reg_wake;
    logic [31:0] reg_sleep;
    logic [31:0] reg_run_reach;
    logic [31:0] reg_coef;
    logic [EV_W-1:0] irq_status;
    logic [EV_W-1:0] irq_mask;
    logic [31:0] tick_cnt;
    logic tick;
    dam_state_t state;
    dam_state_t next_state;
    dam_do_t do_q;
    dam_do_t next_do;
    logic [5:0] run_sub;
    logic [15:0] run_tenths;
    logic [15:0] sleep_cnt;
    logic [15:0] wake_cnt;
    logic [15:0] power_q;

    // bus decode
    wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    // writes land at the edge where the master samples ack high
    wire bus_wr = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i & ce_i;
    logic [31:0] be_mask;
    for (genvar b = 0; b < 4; b++)
    begin : g_lane
        assign be_mask[8*b +: 8] = {8{wb_sel_i[b]}};
    end
    wire [31:0] wr_keep = ~be_mask;
    wire [31:0] wr_new = wb_dat_i & be_mask;
    wire wr_ctrl = bus_wr & (wb_adr_i == ADDR_CTRL);
    wire wr_cur_a = bus_wr & (wb_adr_i == ADDR_CUR_A);
    wire wr_cur_b = bus_wr & (wb_adr_i == ADDR_CUR_B);
    wire wr_dur = bus_wr & (wb_adr_i == ADDR_DURATION);
    wire wr_ai1 = bus_wr & (wb_adr_i == ADDR_AI1_LIMITS);
    wire wr_temp = bus_wr & (wb_adr_i == ADDR_TEMP);
    wire wr_wake = bus_wr & (wb_adr_i == ADDR_WAKE);
    wire wr_sleep = bus_wr & (wb_adr_i == ADDR_SLEEP);
    wire wr_reach = bus_wr & (wb_adr_i == ADDR_RUN_REACH);
    wire wr_coef = bus_wr & (wb_adr_i == ADDR_POWER_COEF);
    wire wr_irq_st = bus_wr & (wb_adr_i == ADDR_IRQ_STATUS);
    wire wr_irq_mk = bus_wr & (wb_adr_i == ADDR_IRQ_MASK);

    // configuration fields
    wire timer_en = reg_ctrl[CTRL_TIMER_EN_BIT];
    wire [1:0] timer_src = reg_ctrl[CTRL_SRC_LSB +: 2];
    wire fan_mode = reg_ctrl[CTRL_FAN_BIT];
    wire [15:0] wake_thr = {8'h00, reg_wake[7:0]};
    wire [15:0] wake_delay = reg_wake[31:16];
    wire [15:0] sleep_freq = reg_sleep[15:0];
    wire [15:0] sleep_delay = reg_sleep[31:16];
    wire [15:0] dur_stored = reg_duration[15:0];

    // freeze everything while ce_i is low
    wire upd = tick & ce_i;

    // current windows, one per detector; 17 bits avoid wrap
    logic [1:0] in_window;
    for (genvar d = 0; d < 2; d++)
    begin : g_reach
        wire [31:0] cfg = (d == 0) ? reg_cur_a : reg_cur_b;
        wire [16:0] hi = {1'b0, cfg[15:0]} + {1'b0, cfg[31:16]};
        wire [16:0] cur_w = {1'b0, current_i} + {1'b0, cfg[31:16]};
        assign in_window[d] = (cur_w >= {1'b0, cfg[15:0]}) &&
                              ({1'b0, current_i} <= hi);
    end

    // effective duration: analog full scale equals stored value
    wire [15:0] ai1_clip = (ai1_i > AI_FULL_SCALE) ? AI_FULL_SCALE : ai1_i;
    wire [15:0] ai2_clip = (ai2_i > AI_FULL_SCALE) ? AI_FULL_SCALE : ai2_i;
    wire [31:0] ai1_prod = {16'h0000, dur_stored} * {16'h0000, ai1_clip};
    wire [31:0] ai2_prod = {16'h0000, dur_stored} * {16'h0000, ai2_clip};
    wire [31:0] ai1_dur = ai1_prod / {16'h0000, AI_FULL_SCALE};
    wire [31:0] ai2_dur = ai2_prod / {16'h0000, AI_FULL_SCALE};
    // reserved code falls back to the stored value
    wire [15:0] dur_eff = (timer_src == SRC_AI1) ? ai1_dur[15:0] :
                          (timer_src == SRC_AI2) ? ai2_dur[15:0] :
                          dur_stored;
    wire timer_hit = timer_en && (run_tenths >= dur_eff);
    wire [15:0] remaining = (run_tenths >= dur_eff) ? 16'h0000 :
                            dur_eff - run_tenths;

    // sleep and wakeup decisions
    wire [31:0] wake_prod = {16'h0000, wake_thr} * {16'h0000, max_freq_i};
    wire [31:0] wake_div = wake_prod / WAKE_UNITY;
    wire [15:0] wake_level = wake_div[15:0];
    wire sleep_en = (wake_thr != 16'h0000) ||
                    (sleep_freq != 16'h0000);
    wire freq_low = set_freq_i <= sleep_freq;
    wire freq_high = set_freq_i >= wake_level;
    wire sleep_hit = sleep_en && freq_low &&
                     (sleep_cnt >= sleep_delay);
    wire wake_hit = sleep_en && freq_high &&
                    (wake_cnt >= wake_delay);
    wire start = upd && (next_state == ST_RUN) && (state != ST_RUN);

    // run state machine; the timer stop takes priority over sleep
    always_comb
    begin
        next_state = state;
        unique case (state)
            ST_STOP:
                if (run_cmd_i)
                    next_state = ST_RUN;
            ST_RUN:
                if (!run_cmd_i)
                    next_state = ST_STOP;
                else if (timer_hit)
                    next_state = ST_DONE;
                else if (sleep_hit)
                    next_state = ST_SLEEP;
            ST_SLEEP:
                if (!run_cmd_i)
                    next_state = ST_STOP;
                else if (wake_hit)
                    next_state = ST_RUN;
            ST_DONE:
                if (!run_cmd_i)
                    next_state = ST_STOP;
        endcase
    end

    // next digital output levels
    wire fan_warm = (heatsink_temp_i > FAN_TEMP_C) ||
                    ((heatsink_temp_i == FAN_TEMP_C) && do_q.fan_on);
    always_comb
    begin
        next_do.cur_reach_a = in_window[0];
        next_do.cur_reach_b = in_window[1];
        next_do.ai1_limit = (ai1_i > reg_ai1[31:16]) ||
                            (ai1_i < reg_ai1[15:0]);
        next_do.temp_reached = heatsink_temp_i >= reg_temp[7:0];
        next_do.timing_reached = next_state == ST_DONE;
        next_do.run_time_reached = (state == ST_RUN) &&
            (next_state == ST_RUN) &&
            (run_tenths >= reg_run_reach[15:0]);
        next_do.fan_on = fan_mode ||
            (next_state == ST_RUN) || fan_warm;
    end

    // events are rising edges of outputs and sleep transitions
    logic [EV_W-1:0] ev;
    assign ev[EV_TIMING] = upd & next_do.timing_reached & ~do_q.timing_reached;
    assign ev[EV_RUN_TIME] = upd & next_do.run_time_reached &
                             ~do_q.run_time_reached;
    assign ev[EV_TEMP] = upd & next_do.temp_reached & ~do_q.temp_reached;
    assign ev[EV_AI1] = upd & next_do.ai1_limit & ~do_q.ai1_limit;
    assign ev[EV_SLEEP] = upd & (state == ST_RUN) & (next_state == ST_SLEEP);
    assign ev[EV_WAKE] = upd & (state == ST_SLEEP) & (next_state == ST_RUN);

    // tick divider; a long period so TICK_DIV is shortened in simulation
    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i)
        begin
            tick_cnt <= 32'h0000_0000;
            tick <= 1'b0;
        end
        else if (ce_i)
        begin
            tick <= tick_cnt == 32'(TICK_DIV - 1);
            tick_cnt <= (tick_cnt == 32'(TICK_DIV - 1)) ? 32'h0000_0000 :
                        tick_cnt + 32'h0000_0001;
        end
    end

    // state, outputs and power on the tick
    wire [31:0] pwr_prod = {16'h0000, output_power_i} *
                           {16'h0000, reg_coef[15:0]};
    wire [31:0] pwr_corr = pwr_prod / POWER_UNITY;
    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i)
        begin
            state <= ST_STOP;
            do_q <= '0;
            power_q <= 16'h0000;
        end
        else if (upd)
        begin
            state <= next_state;
            do_q <= next_do;
            power_q <= pwr_corr[15:0];
        end
    end

    // present-run timer in 0.1 minute steps, cleared at every start
    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i)
        begin
            run_sub <= 6'h00;
            run_tenths <= 16'h0000;
        end
        else if (start)
        begin
            run_sub <= 6'h00;
            run_tenths <= 16'h0000;
        end
        else if (upd && state == ST_RUN)
        begin
            run_sub <= (run_sub == 6'(TICKS_PER_TENTH_MIN - 1)) ? 6'h00 :
                       run_sub + 6'h01;
            if (run_sub == 6'(TICKS_PER_TENTH_MIN - 1) &&
                run_tenths != 16'hFFFF)
                run_tenths <= run_tenths + 16'h0001;
        end
    end

    // sleep and wake delay counters in ticks of 0.1 s
    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i)
        begin
            sleep_cnt <= 16'h0000;
            wake_cnt <= 16'h0000;
        end
        else if (upd)
        begin
            sleep_cnt <= (state == ST_RUN && freq_low) ?
                sleep_cnt + {15'h0000, sleep_cnt != 16'hFFFF} : 16'h0000;
            wake_cnt <= (state == ST_SLEEP && run_cmd_i && freq_high) ?
                wake_cnt + {15'h0000, wake_cnt != 16'hFFFF} : 16'h0000;
        end
    end

    // configuration registers
    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i)
        begin
            reg_ctrl <= RST_CTRL;
            reg_cur_a <= RST_CUR;
            reg_cur_b <= RST_CUR;
            reg_duration <= RST_DURATION;
            reg_ai1 <= RST_AI1_LIMITS;
            reg_temp <= RST_TEMP;
            reg_wake <= RST_WAKE;
            reg_sleep <= RST_SLEEP;
            reg_run_reach <= RST_RUN_REACH;
            reg_coef <= RST_POWER_COEF;
            irq_mask <= '0;
        end
        else
        begin
            if (wr_ctrl)
                reg_ctrl <= ((reg_ctrl & wr_keep) | wr_new) & MASK_CTRL;
            if (wr_cur_a)
                reg_cur_a <= ((reg_cur_a & wr_keep) | wr_new) & MASK_FULL;
            if (wr_cur_b)
                reg_cur_b <= ((reg_cur_b & wr_keep) | wr_new) & MASK_FULL;
            if (wr_dur)
                reg_duration <= ((reg_duration & wr_keep) | wr_new) &
                                MASK_LOW16;
            if (wr_ai1)
                reg_ai1 <= ((reg_ai1 & wr_keep) | wr_new) & MASK_FULL;
            if (wr_temp)
                reg_temp <= ((reg_temp & wr_keep) | wr_new) & MASK_TEMP;
            if (wr_wake)
                reg_wake <= ((reg_wake & wr_keep) | wr_new) & MASK_WAKE;
            if (wr_sleep)
                reg_sleep <= ((reg_sleep & wr_keep) | wr_new) & MASK_FULL;
            if (wr_reach)
                reg_run_reach <= ((reg_run_reach & wr_keep) | wr_new) &
                                 MASK_LOW16;
            if (wr_coef)
                reg_coef <= ((reg_coef & wr_keep) | wr_new) & MASK_LOW16;
            if (wr_irq_mk)
                irq_mask <= wr_new[EV_W-1:0];
        end
    end

    // sticky events; a set in the clearing cycle survives
    wire [EV_W-1:0] irq_clr = wr_irq_st ? wr_new[EV_W-1:0] : '0;
    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i)
            irq_status <= '0;
        else if (ce_i)
            irq_status <= (irq_status & ~irq_clr) | ev;
    end

    // read selection; unmapped offsets read zero
    wire [31:0] status_word = {22'h00_0000, sleep_en, state, do_q};
    wire [31:0] rd_data =
        (wb_adr_i == ADDR_CTRL) ? reg_ctrl :
        (wb_adr_i == ADDR_CUR_A) ? reg_cur_a :
        (wb_adr_i == ADDR_CUR_B) ? reg_cur_b :
        (wb_adr_i == ADDR_DURATION) ? reg_duration :
        (wb_adr_i == ADDR_AI1_LIMITS) ? reg_ai1 :
        (wb_adr_i == ADDR_TEMP) ? reg_temp :
        (wb_adr_i == ADDR_WAKE) ? reg_wake :
        (wb_adr_i == ADDR_SLEEP) ? reg_sleep :
        (wb_adr_i == ADDR_RUN_REACH) ? reg_run_reach :
        (wb_adr_i == ADDR_POWER_COEF) ? reg_coef :
        (wb_adr_i == ADDR_STATUS) ? status_word :
        (wb_adr_i == ADDR_MONITOR) ? {power_q, remaining} :
        (wb_adr_i == ADDR_IRQ_STATUS) ? {26'h000_0000, irq_status} :
        (wb_adr_i == ADDR_IRQ_MASK) ? {26'h000_0000, irq_mask} :
        32'h0000_0000;

    // one wait state: ack and data one edge after the request
    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end
        else if (ce_i)
        begin
            wb_ack_o <= bus_req;
            wb_dat_o <= bus_req ? rd_data : 32'h0000_0000;
        end
    end

    // output drive
    assign do_o = do_q;
    assign drive_run_o = state == ST_RUN;
    assign sleeping_o = state == ST_SLEEP;
    assign run_timer_remaining_monitor_o = remaining;
    assign output_power_monitor_o = power_q;
    assign irq_o = |(irq_status & irq_mask);

    // checks
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);

    sequence s_run_tick;
        upd && state == ST_RUN && run_cmd_i;
    endsequence
    sequence s_stopped;
        state == ST_DONE && do_q.timing_reached && !drive_run_o;
    endsequence

    property p_timeout;
        s_run_tick ##0 timer_hit |=> s_stopped;
    endproperty
    a_timeout: assert property (p_timeout)
        else $error("timer did not stop the drive");
    property p_no_timeout;
        s_run_tick ##0 !timer_en |=> state != ST_DONE;
    endproperty
    a_no_timeout: assert property (p_no_timeout)
        else $error("timer stopped drive while disabled");
    property p_start_clear;
        upd && state == ST_STOP && run_cmd_i |=>
            state == ST_RUN && run_tenths == 16'h0000;
    endproperty
    a_start_clear: assert property (p_start_clear)
        else $error("run timer not cleared at start");
    property p_ai1;
        upd && (ai1_i > reg_ai1[31:16] || ai1_i < reg_ai1[15:0]) |=>
            do_o.ai1_limit;
    endproperty
    a_ai1: assert property (p_ai1)
        else $error("analog limit output missing");
    property p_temp;
        upd && heatsink_temp_i >= reg_temp[7:0] |=> do_o.temp_reached;
    endproperty
    a_temp: assert property (p_temp)
        else $error("temperature output missing");
    property p_fan_always;
        upd && fan_mode |=> do_o.fan_on;
    endproperty
    a_fan_always: assert property (p_fan_always)
        else $error("fan off in always mode");
    property p_fan_cold;
        upd && !fan_mode && next_state != ST_RUN &&
            heatsink_temp_i < FAN_TEMP_C |=> !do_o.fan_on;
    endproperty
    a_fan_cold: assert property (p_fan_cold)
        else $error("fan on while stopped and cold");
    property p_sleep_off;
        s_run_tick ##0 wake_thr == 16'h0000 && sleep_freq == 16'h0000
            |=> !sleeping_o;
    endproperty
    a_sleep_off: assert property (p_sleep_off)
        else $error("slept with sleep disabled");
    property p_sleep_enter;
        s_run_tick ##0 !timer_hit && sleep_hit |=>
            sleeping_o && !drive_run_o;
    endproperty
    a_sleep_enter: assert property (p_sleep_enter)
        else $error("sleep not entered");
    property p_reach_a;
        upd && {1'b0, current_i} + {1'b0, reg_cur_a[31:16]} >=
            {1'b0, reg_cur_a[15:0]} && {1'b0, current_i} <=
            {1'b0, reg_cur_a[15:0]} + {1'b0, reg_cur_a[31:16]}
            |=> do_o.cur_reach_a;
    endproperty
    a_reach_a: assert property (p_reach_a)
        else $error("current reach output missing");
    property p_power;
        upd |=> output_power_monitor_o == 16'(32'($past(output_power_i)) *
            32'($past(reg_coef[15:0])) / POWER_UNITY);
    endproperty
    a_power: assert property (p_power)
        else $error("corrected power wrong");

endmodule // dam_top

`default_nettype wire

/* dv/dam_top_tb.sv */
/* bench for dam_top: registers, detectors, timer, sleep, fan, power.
   assumes the tick shortened to 4 clocks and ce_i held high. */
`default_nettype none
module dam_top_tb
    import dam_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TD = 4;
    logic clk_sys_i = 0, reset_i = 1, wb_we_i = 0, wb_cyc_i = 0;
    logic wb_stb_i = 0, run_cmd_i = 0, wb_ack_o, drive_run_o;
    logic sleeping_o, irq_o;
    logic [7:0] wb_adr_i = 0, heatsink_temp_i = 8'h14;
    logic [31:0] wb_dat_i = 0, wb_dat_o, rd;
    logic [15:0] current_i = 0, ai1_i = 16'h01F4, ai2_i = 0, rem, pwr;
    logic [15:0] set_freq_i = 16'h07D0, max_freq_i = 16'h03E8;
    logic [15:0] output_power_i = 16'h03E8;
    dam_do_t do_o;
    int n_mismatch = 0;
    int samples_checked = 0;
    // free-running 20 MHz clock
    always #25 clk_sys_i = ~clk_sys_i;
    dam_top #(.TICK_DIV(TD)) dut_u (.clk_sys_i(clk_sys_i),
        .reset_i(reset_i), .ce_i(1'b1), .wb_adr_i(wb_adr_i),
        .wb_dat_i(wb_dat_i), .wb_sel_i(4'hF), .wb_we_i(wb_we_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .run_cmd_i(run_cmd_i), .current_i(current_i),
        .ai1_i(ai1_i), .ai2_i(ai2_i), .heatsink_temp_i(heatsink_temp_i),
        .set_freq_i(set_freq_i), .max_freq_i(max_freq_i),
        .output_power_i(output_power_i), .do_o(do_o),
        .drive_run_o(drive_run_o), .sleeping_o(sleeping_o),
        .run_timer_remaining_monitor_o(rem),
        .output_power_monitor_o(pwr), .irq_o(irq_o));
    task automatic chk(input string nm, input logic [31:0] e, g);
        samples_checked++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    // classic cycle; request held until ack is sampled high, no own limit
    task automatic wb(input logic we, input logic [7:0] a, input int d);
        wb_cyc_i <= 1;
        wb_stb_i <= 1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do
            @(posedge clk_sys_i);
        while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 0;
        wb_stb_i <= 0;
        @(posedge clk_sys_i);
    endtask
    // enough clocks for n ticks plus the output register
    task automatic tk(input int n);
        repeat (n * TD + 2) @(posedge clk_sys_i);
    endtask
    task automatic final_report;
        if (n_mismatch == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic t_regs;
        wb(0, ADDR_CUR_A, 0);
        chk("cur_a", RST_CUR, rd);
        wb(0, ADDR_DURATION, 0);
        chk("dur", RST_DURATION, rd);
        wb(0, ADDR_AI1_LIMITS, 0);
        chk("ai_lim", RST_AI1_LIMITS, rd);
        wb(0, ADDR_TEMP, 0);
        chk("temp", RST_TEMP, rd);
        wb(0, ADDR_WAKE, 0);
        chk("wake", RST_WAKE, rd);
        wb(0, ADDR_POWER_COEF, 0);
        chk("coef", RST_POWER_COEF, rd);
        wb(0, 8'h3C, 0);
        chk("unmapped", 0, rd);
    endtask
    // window edges are inclusive; b has zero width
    task automatic t_reach;
        wb(1, ADDR_CUR_A, 32'h0014_01F4);
        wb(1, ADDR_CUR_B, 32'h0000_0208);
        current_i <= 16'h0208;
        tk(1);
        chk("ra", 1, do_o.cur_reach_a);
        chk("rb", 1, do_o.cur_reach_b);
        current_i <= 16'h0209;
        tk(1);
        chk("ra", 0, do_o.cur_reach_a);
        chk("rb", 0, do_o.cur_reach_b);
    endtask
    task automatic t_lim_irq;
        ai1_i <= 16'h0135;
        heatsink_temp_i <= 8'h4B;
        wb(1, ADDR_IRQ_MASK, 32'h04);
        tk(1);
        chk("ai", 1, do_o.ai1_limit);
        chk("tr", 1, do_o.temp_reached);
        chk("irq", 1, irq_o);
        wb(1, ADDR_IRQ_STATUS, 32'h3F);
        chk("irq", 0, irq_o);
        ai1_i <= 16'h02A8;
        heatsink_temp_i <= 8'h4A;
        tk(1);
        chk("ai", 0, do_o.ai1_limit);
        chk("tr", 0, do_o.temp_reached);
    endtask
    // one tenth of a minute is 60 ticks
    task automatic t_timer;
        wb(1, ADDR_DURATION, 1);
        wb(1, ADDR_CTRL, 1);
        run_cmd_i <= 1;
        tk(1);
        chk("run", 1, drive_run_o);
        chk("rem", 1, rem);
        tk(55);
        chk("run", 1, drive_run_o);
        tk(8);
        chk("run", 0, drive_run_o);
        chk("rem", 0, rem);
        chk("timed", 1, do_o.timing_reached);
        run_cmd_i <= 0;
        wb(1, ADDR_RUN_REACH, 1);
        tk(2);
        wb(1, ADDR_CTRL, 0);
        run_cmd_i <= 1;
        tk(1);
        chk("rem", 1, rem);
        tk(55);
        chk("rt", 0, do_o.run_time_reached);
        tk(10);
        chk("rt", 1, do_o.run_time_reached);
        chk("run", 1, drive_run_o);
    endtask
    // set frequency keeps tracking while asleep
    task automatic t_sleep;
        wb(1, ADDR_SLEEP, 32'h0002_0064);
        set_freq_i <= 16'h0064;
        tk(5);
        chk("slp", 1, sleeping_o);
        chk("run", 0, drive_run_o);
        set_freq_i <= 16'h02EE;
        tk(2);
        chk("run", 1, drive_run_o);
        wb(1, ADDR_WAKE, 0);
        wb(1, ADDR_SLEEP, 0);
        set_freq_i <= 0;
        tk(5);
        chk("slp", 0, sleeping_o);
    endtask
    task automatic t_pwr_fan;
        wb(1, ADDR_POWER_COEF, 32'h01F4);
        tk(1);
        chk("pwr", 16'h01F4, pwr);
        chk("fan", 1, do_o.fan_on);
        run_cmd_i <= 0;
        heatsink_temp_i <= 8'h29;
        tk(2);
        chk("fan", 1, do_o.fan_on);
        heatsink_temp_i <= 8'h27;
        tk(1);
        chk("fan", 0, do_o.fan_on);
        wb(1, ADDR_CTRL, 32'h08);
        tk(1);
        chk("fan", 1, do_o.fan_on);
    endtask
    // run timer still zero after the last short run, so remaining equals the effective duration; ai1 clips
    task automatic t_src;
        wb(1, ADDR_DURATION, 32'h64);
        ai1_i <= 16'h07D0;
        ai2_i <= 16'h0320;
        wb(1, ADDR_CTRL, 32'h0A);
        chk("src1", 16'h0064, rem);
        wb(1, ADDR_CTRL, 32'h0C);
        chk("src2", 16'h0050, rem);
        wb(1, ADDR_CTRL, 32'h0E);
        chk("src3", 16'h0064, rem);
    endtask
    initial
    begin
        repeat (3) @(posedge clk_sys_i);
        reset_i <= 0;
        t_regs;
        t_reach;
        t_lim_irq;
        t_timer;
        t_sleep;
        t_pwr_fan;
        t_src;
        final_report;
    end
    // watchdog well past the expected run of about 36 us
    initial
    begin
        #400000;
        n_mismatch++;
        final_report;
    end
endmodule // dam_top_tb
`default_nettype wire
